// ### bench/pgc_global_regs_assertions.sv
// concurrent checks on the global register set ports
`timescale 1ns/1ns
module pgc_global_regs_checker
    import pgc_pkg::*;
#(
    parameter int SLEEP_T0_CYCLES = 10,
    parameter int SLEEP_T1_CYCLES = 20,
    parameter int SLEEP_T2_CYCLES = 40
) (
    // clocks and reset
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_link_clock,
    // link side
    input wire logic i_link_req,
    input wire logic o_link_ack,
    input wire logic o_link_busy,
    input wire logic [DATA_W-1:0] o_link_rdata,
    // core side
    input wire logic i_core_undervoltage,
    input wire logic i_nv_refresh_done,
    input wire logic o_irq,
    input wire logic o_write_unlocked,
    input wire logic o_soft_reset,
    input wire logic o_ignore_return_faults,
    input wire logic o_overload_timer_off,
    input wire logic o_sleep_fault_timer_en,
    input wire logic [SLEEP_CNT_W-1:0] o_sleep_fault_cycles,
    input wire logic o_nv_refresh_req,
    input wire logic o_supply_ready_flag
);
    // ========
    // link handshake
    take_sets_busy_a: assert property (@(posedge i_link_clock) disable iff (!i_reset_n)
        i_link_req && !o_link_busy |=> o_link_busy) else $error("request not taken");
    busy_ends_ack_a: assert property (@(posedge i_link_clock) disable iff (!i_reset_n)
        $fell(o_link_busy) |-> o_link_ack) else $error("busy fell without ack");
    ack_pulse_a: assert property (@(posedge i_link_clock) disable iff (!i_reset_n)
        o_link_ack |=> !o_link_ack) else $error("ack longer than one cycle");
    ack_bound_a: assert property (@(posedge i_link_clock) disable iff (!i_reset_n)
        $rose(o_link_busy) |-> ##[4:30] o_link_ack) else $error("no ack in time");
    rdata_held_a: assert property (@(posedge i_link_clock) disable iff (!i_reset_n)
        !o_link_ack |-> $stable(o_link_rdata)) else $error("read word moved without ack");
    // ========
    // core controls
    uv_irq_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        i_core_undervoltage [*6] |-> o_irq) else $error("undervoltage gives no interrupt");
    soft_reset_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        o_soft_reset |=> !o_soft_reset && !o_write_unlocked && o_supply_ready_flag
        && !o_ignore_return_faults && !o_overload_timer_off) else $error("soft reset left state");
    sleep_len_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        o_sleep_fault_timer_en |-> o_sleep_fault_cycles inside {SLEEP_T0_CYCLES, SLEEP_T1_CYCLES,
        SLEEP_T2_CYCLES}) else $error("sleep timer length off table");
    refresh_end_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        $fell(o_nv_refresh_req) |-> $past(i_nv_refresh_done) || $past(o_soft_reset))
        else $error("refresh ended without done");
    ack_seen_c: cover property (@(posedge i_link_clock) disable iff (!i_reset_n) o_link_ack);
    soft_seen_c: cover property (@(posedge i_clock) disable iff (!i_reset_n) o_soft_reset);
    refresh_seen_c: cover property (@(posedge i_clock) disable iff (!i_reset_n) $fell(o_nv_refresh_req));
endmodule : pgc_global_regs_checker

bind pgc_global_regs pgc_global_regs_checker #(
    .SLEEP_T0_CYCLES(SLEEP_T0_CYCLES),
    .SLEEP_T1_CYCLES(SLEEP_T1_CYCLES),
    .SLEEP_T2_CYCLES(SLEEP_T2_CYCLES)
) u_checker (.i_clock, .i_reset_n, .i_link_clock, .i_link_req, .o_link_ack, .o_link_busy, .o_link_rdata,
    .i_core_undervoltage, .i_nv_refresh_done, .o_irq, .o_write_unlocked, .o_soft_reset,
    .o_ignore_return_faults, .o_overload_timer_off, .o_sleep_fault_timer_en, .o_sleep_fault_cycles,
    .o_nv_refresh_req, .o_supply_ready_flag);

// ### bench/pgc_global_regs_tb_top.sv
// testbench for the global register set
`timescale 1ns/1ns
module pgc_global_regs_tb_top
    import pgc_pkg::*;
;
    localparam int LEN [3] = '{10, 20, 40};
    logic clock, link_clock, reset_n, link_req, link_ack, link_busy, irq, unlocked, soft_reset;
    logic ign_ret, ovl_off, sleep_en, refresh_req, supply_rdy, auto_pin, host_wake, dev_wake, ok, seen;
    logic [4:0] src, pg;
    logic [15:0] link_rdata, q;
    logic [SLEEP_CNT_W-1:0] sleep_cycles;
    pgc_request_t link_request;
    int n_errors, checked;

    pgc_global_regs #(.SLEEP_T0_CYCLES(LEN[0]), .SLEEP_T1_CYCLES(LEN[1]), .SLEEP_T2_CYCLES(LEN[2])) u_dut (
        .i_clock(clock), .i_reset_n(reset_n), .i_link_clock(link_clock), .i_link_req(link_req),
        .i_link_request(link_request), .o_link_ack(link_ack), .o_link_busy(link_busy),
        .o_link_rdata(link_rdata), .i_memory_fault(src[0]), .i_return_breaker_trip(src[1]),
        .i_sleep_return_fault(src[2]), .i_nv_refresh_done(src[3]), .i_core_undervoltage(src[4]),
        .i_port_power_good(pg), .i_auto_pin(auto_pin), .i_host_wake_pin_level(host_wake),
        .i_device_wake_pin_drive(dev_wake), .o_irq(irq), .o_write_unlocked(unlocked),
        .o_soft_reset(soft_reset), .o_ignore_return_faults(ign_ret), .o_overload_timer_off(ovl_off),
        .o_sleep_fault_timer_en(sleep_en), .o_sleep_fault_cycles(sleep_cycles),
        .o_nv_refresh_req(refresh_req), .o_supply_ready_flag(supply_rdy));

    pgc_host_model u_host (.i_link_clock(link_clock), .i_link_ack(link_ack), .i_link_busy(link_busy),
        .i_link_rdata(link_rdata), .o_link_req(link_req), .o_link_request(link_request));

    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    initial
    begin
        link_clock = 1'b0;
        #3;
        forever #6 link_clock = ~link_clock;
    end

    // soft reset is a one cycle pulse, so it is latched here
    always @(posedge clock)
    begin
        seen <= (seen === 1'b1) || (soft_reset === 1'b1);
    end

    // ========
    // access and check tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d, input logic pe);
        u_host.xfer(w, a, d, pe, q, ok);
        if (ok !== 1'b1)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, ok, 1'b1);
            conclude();
        end
    endtask : acc

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        acc(1'b0, a, 16'h0000, 1'b0);
        chk(32'(q), 32'(exp));
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        acc(1'b1, a, d, 1'b0);
    endtask : wr

    task automatic hit(input logic [4:0] v, input int n);
        @(posedge clock);
        src <= v;
        repeat (n) @(posedge clock);
        src <= 5'h00;
        repeat (4) @(posedge clock);
    endtask : hit

    task conclude;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : conclude

    // ========
    // main sequence
    initial
    begin
        reset_n = 1'b0;
        src = 5'h00;
        pg = 5'h15;
        auto_pin = 1'b1;
        host_wake = 1'b0;
        dev_wake = 1'b1;
        n_errors = 0;
        checked = 0;
        repeat (4) @(posedge clock);
        reset_n <= 1'b1;
        repeat (4) @(posedge clock);
        rd(OFS_FAULT_EVENTS, 16'h0010);
        rd(OFS_FAULT_MASK, 16'h000f);
        rd(OFS_CAPABILITY, 16'h0025);
        rd(OFS_PIN_STATUS, 16'h015a);
        rd(OFS_COMMAND, 16'h00a0);
        rd(OFS_CONFIG, 16'h0009);
        wr(OFS_FAULT_MASK, 16'h0000);
        rd(OFS_FAULT_MASK, 16'h000f);
        rd(OFS_FAULT_EVENTS, 16'h0018);
        wr(OFS_FAULT_EVENTS, 16'h0008);
        rd(OFS_FAULT_EVENTS, 16'h0010);
        wr(OFS_FAULT_EVENTS, 16'hfff0);
        rd(8'h0a, 16'h0000);
        wr(OFS_CAPABILITY, 16'hffff);
        rd(OFS_CAPABILITY, 16'h0025);
        rd(OFS_FAULT_EVENTS, 16'h0008);
        acc(1'b1, OFS_CONFIG, 16'h0000, 1'b1);
        rd(OFS_CONFIG, 16'h0009);
        rd(OFS_FAULT_EVENTS, 16'h000c);
        wr(OFS_FAULT_EVENTS, 16'h000c);
        chk(32'(irq), 32'h0);
        wr(OFS_COMMAND, 16'h0005);
        chk(32'(unlocked), 32'h1);
        rd(OFS_COMMAND, 16'h0005);
        wr(OFS_FAULT_MASK, 16'hfffd);
        rd(OFS_FAULT_MASK, 16'h000d);
        hit(5'h01, 1);
        chk(32'(irq), 32'h0);
        rd(OFS_FAULT_EVENTS, 16'h0002);
        wr(OFS_FAULT_MASK, 16'h000f);
        chk(32'(irq), 32'h1);
        wr(OFS_FAULT_EVENTS, 16'h0002);
        for (int i = 1; i < 3; i++)
        begin
            hit(5'h01 << i, 1);
            rd(OFS_FAULT_EVENTS, 16'h0001);
            wr(OFS_FAULT_EVENTS, 16'h0001);
        end
        wr(OFS_CONFIG, 16'hffff);
        rd(OFS_CONFIG, 16'h003f);
        chk(32'({ign_ret, ovl_off, sleep_en, refresh_req, supply_rdy}), 32'h1b);
        hit(5'h08, 1);
        rd(OFS_CONFIG, 16'h003d);
        for (int s = 0; s < 3; s++)
        begin
            wr(OFS_CONFIG, 16'(s * 4 + 1));
            repeat (2) @(posedge clock);
            chk(32'({sleep_en, sleep_cycles}), 32'({1'b1, 22'(LEN[s])}));
        end
        wr(OFS_COMMAND, 16'h00a0);
        chk(32'(unlocked), 32'h0);
        wr(OFS_CONFIG, 16'h0020);
        rd(OFS_CONFIG, 16'h0009);
        wr(OFS_COMMAND, 16'h0005);
        wr(OFS_CONFIG, 16'h0030);
        wr(OFS_COMMAND, 16'h7300);
        chk(32'(seen), 32'h1);
        rd(OFS_CONFIG, 16'h0009);
        rd(OFS_COMMAND, 16'h00a0);
        wr(OFS_FAULT_EVENTS, 16'h0010);
        rd(OFS_FAULT_EVENTS, 16'h0000);
        hit(5'h10, 8);
        rd(OFS_FAULT_EVENTS, 16'h0010);
        chk(32'(irq), 32'h1);
        conclude();
    end
endmodule : pgc_global_regs_tb_top

// ### bench/pgc_host_model.sv
// host side model issuing parsed link requests on the link clock
`timescale 1ns/1ns
module pgc_host_model
    import pgc_pkg::*;
(
    // link answer
    input wire logic i_link_clock,
    input wire logic i_link_ack,
    input wire logic i_link_busy,
    input wire logic [DATA_W-1:0] i_link_rdata,
    // link request
    output logic o_link_req,
    output pgc_request_t o_link_request
);
    initial
    begin
        o_link_req = 1'b0;
        o_link_request = '0;
    end

    // ========
    // one transfer; drives just after an edge, ok low if never answered
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [15:0] d, input logic pe,
        output logic [15:0] q, output logic ok);
        int n;
        n = 0;
        @(posedge i_link_clock);
        #1;
        o_link_req = 1'b1;
        o_link_request = '{write: wr, addr: a, wdata: d, packet_error: pe};
        do
        begin
            @(posedge i_link_clock);
            #1;
            n++;
        end
        while (!i_link_busy && n < 40);
        // drop the request once taken so it is not taken twice
        o_link_req = 1'b0;
        while (!i_link_ack && n < 80)
        begin
            @(posedge i_link_clock);
            #1;
            n++;
        end
        q = i_link_rdata;
        ok = i_link_ack;
        // released word shows a changed pattern, not the old value
        o_link_request.wdata = ~d;
    endtask : xfer
endmodule : pgc_host_model

// ### src/pgc_global_regs.sv
// global fault, status, command and configuration registers with link crossing
`timescale 1ns/1ns
module pgc_global_regs
    import pgc_pkg::*;
#(
    parameter int SLEEP_T0_CYCLES = SLEEP_T0_CYC,
    parameter int SLEEP_T1_CYCLES = SLEEP_T1_CYC,
    parameter int SLEEP_T2_CYCLES = SLEEP_T2_CYC
) (
    // core clock and reset
    input wire logic i_clock,
    input wire logic i_reset_n,
    // link side, on the link clock
    input wire logic i_link_clock,
    input wire logic i_link_req,
    input wire pgc_request_t i_link_request,
    output logic o_link_ack,
    output logic o_link_busy,
    output logic [DATA_W-1:0] o_link_rdata,
    // fault sources and refresh completion from core logic
    input wire logic i_memory_fault,
    input wire logic i_return_breaker_trip,
    input wire logic i_sleep_return_fault,
    input wire logic i_nv_refresh_done,
    // asynchronous pin and analog levels
    input wire logic i_core_undervoltage,
    input wire logic [NUM_PORTS-1:0] i_port_power_good,
    input wire logic i_auto_pin,
    input wire logic i_host_wake_pin_level,
    input wire logic i_device_wake_pin_drive,
    // controls to the port logic
    output logic o_irq,
    output logic o_write_unlocked,
    output logic o_soft_reset,
    output logic o_ignore_return_faults,
    output logic o_overload_timer_off,
    output logic o_sleep_fault_timer_en,
    output logic [SLEEP_CNT_W-1:0] o_sleep_fault_cycles,
    output logic o_nv_refresh_req,
    output logic o_supply_ready_flag
);

    // =====================================================================
    // link domain: capture request, hand it over by toggle
    pgc_request_t hold_q;
    logic req_tgl_q;
    logic ack_seen_q;
    logic ack_tgl_link;
    logic ack_tgl_q;
    logic [DATA_W-1:0] rdata_q;
    wire link_take = i_link_req && !o_link_busy;
    wire ack_arrived = ack_tgl_link != ack_seen_q;

    // request fields stay frozen while busy, so the core can read them directly
    always_ff @(posedge i_link_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            hold_q <= '0;
            req_tgl_q <= 1'b0;
        end
        else if (link_take)
        begin
            hold_q <= i_link_request;
            req_tgl_q <= ~req_tgl_q;
        end
    end

    always_ff @(posedge i_link_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_link_busy <= 1'b0;
            o_link_ack <= 1'b0;
            ack_seen_q <= 1'b0;
            o_link_rdata <= '0;
        end
        else
        begin
            ack_seen_q <= ack_tgl_link;
            o_link_ack <= ack_arrived;
            if (ack_arrived)
            begin
                o_link_rdata <= rdata_q;
                o_link_busy <= 1'b0;
            end
            else if (link_take)
            begin
                o_link_busy <= 1'b1;
            end
        end
    end

    pgc_sync #(
        .WIDTH(1)
    ) u_ack_sync (
        .i_clock(i_link_clock),
        .i_reset_n(i_reset_n),
        .i_async(ack_tgl_q),
        .o_sync(ack_tgl_link)
    );

    // =====================================================================
    // core domain: synchronise request toggle and pins
    logic req_tgl_core;
    logic req_seen_q;
    logic [PIN_W-1:0] pins_sync;
    logic uv_sync;
    pgc_state_t state_q;
    pgc_state_t state_d;

    pgc_sync #(
        .WIDTH(PIN_W + 2)
    ) u_core_sync (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_async({req_tgl_q, i_core_undervoltage, i_port_power_good,
                  i_auto_pin, i_host_wake_pin_level, i_device_wake_pin_drive}),
        .o_sync({req_tgl_core, uv_sync, pins_sync})
    );

    wire req_new = req_tgl_core != req_seen_q;
    wire go = state_q == ST_EXEC;

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE:
            begin
                if (req_new)
                begin
                    state_d = ST_EXEC;
                end
            end
            ST_EXEC:
            begin
                state_d = ST_IDLE;
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // handshake state is kept out of soft reset so the link never loses step
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_q <= ST_IDLE;
            req_seen_q <= 1'b0;
            ack_tgl_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            if (state_q == ST_IDLE && req_new)
            begin
                req_seen_q <= req_tgl_core;
            end
            if (go)
            begin
                ack_tgl_q <= ~ack_tgl_q;
            end
        end
    end

    // =====================================================================
    // address decode
    logic [EV_W-1:0] ev_q;
    logic [MASK_W-1:0] mask_q;
    logic [7:0] protect_q;
    logic unlocked_q;
    logic [CFG_W-1:0] cfg_q;

    wire hit_ev = hold_q.addr == OFS_FAULT_EVENTS;
    wire hit_mask = hold_q.addr == OFS_FAULT_MASK;
    wire hit_cap = hold_q.addr == OFS_CAPABILITY;
    wire hit_pin = hold_q.addr == OFS_PIN_STATUS;
    wire hit_cmd = hold_q.addr == OFS_COMMAND;
    wire hit_cfg = hold_q.addr == OFS_CONFIG;
    wire addr_ok = hit_ev || hit_mask || hit_cap || hit_pin || hit_cmd || hit_cfg;
    wire frame_ok = go && !hold_q.packet_error;
    wire wr = frame_ok && hold_q.write;
    wire wr_prot = wr && unlocked_q;
    wire wr_locked = wr && !unlocked_q && (hit_mask || hit_cfg);
    wire bad_cmd = frame_ok && (!addr_ok || (hold_q.write && (hit_cap || hit_pin)) || wr_locked); // RL2
    wire pec_evt = go && hold_q.packet_error; // RL3
    wire [7:0] wr_lo = hold_q.wdata[7:0];
    wire [7:0] wr_hi = hold_q.wdata[15:8];

    // =====================================================================
    // fault events, set wins over clear
    wire [EV_W-1:0] ev_set = {uv_sync, // RL1
                              bad_cmd,
                              pec_evt,
                              i_memory_fault, // RL4
                              i_return_breaker_trip || i_sleep_return_fault}; // RL5
    wire [EV_W-1:0] ev_clr = (wr && hit_ev) ? hold_q.wdata[EV_W-1:0] : '0; // RL6
    wire [EV_W-1:0] ev_d = (ev_q & ~ev_clr) | ev_set;
    wire [MASK_W-1:0] mask_d = (wr_prot && hit_mask) ? hold_q.wdata[MASK_W-1:0] : mask_q; // RL7 RL23
    wire irq_d = ev_q[EV_UNDERVOLTAGE] || |(ev_q[MASK_W-1:0] & mask_q); // RL22 RL1 RL7

    // =====================================================================
    // command word
    wire wr_cmd = wr && hit_cmd;
    wire soft_reset_d = wr_cmd && wr_hi == SOFT_RESET_CODE; // RL11
    wire [7:0] protect_d = wr_cmd ? wr_lo : protect_q; // RL14
    wire unlocked_d = (wr_cmd && wr_lo == UNLOCK_KEY) ? 1'b1 // RL12
                    : (wr_cmd && wr_lo == LOCK_KEY) ? 1'b0 // RL13
                    : unlocked_q;

    // =====================================================================
    // configuration; refresh request set wins over its completion
    wire wr_cfg = wr_prot && hit_cfg;
    wire refresh_keep = cfg_q[CFG_REFRESH] && !i_nv_refresh_done; // RL18
    wire [CFG_W-1:0] cfg_wr_val = {hold_q.wdata[CFG_W-1:CFG_REFRESH+1],
                                   hold_q.wdata[CFG_REFRESH] || refresh_keep,
                                   hold_q.wdata[CFG_SUPPLY_READY]}; // RL19
    wire [CFG_W-1:0] cfg_hold_val = {cfg_q[CFG_W-1:CFG_REFRESH+1], refresh_keep, cfg_q[CFG_SUPPLY_READY]};
    wire [CFG_W-1:0] cfg_d = wr_cfg ? cfg_wr_val : cfg_hold_val; // RL23
    wire [1:0] sleep_sel = cfg_q[CFG_SLEEP_SEL_HI:CFG_SLEEP_SEL_LO];
    wire [SLEEP_CNT_W-1:0] sleep_cycles_d = (sleep_sel == 2'h0) ? SLEEP_CNT_W'(SLEEP_T0_CYCLES) // RL17
                                          : (sleep_sel == 2'h1) ? SLEEP_CNT_W'(SLEEP_T1_CYCLES)
                                          : SLEEP_CNT_W'(SLEEP_T2_CYCLES);

    // =====================================================================
    // read data, reserved bits zero
    wire [DATA_W-1:0] rd_pin = {{(DATA_W-PIN_W-PIN_LSB){1'b0}}, pins_sync, 1'b0}; // RL9 RL10
    wire [DATA_W-1:0] rd_word = hit_ev ? {{(DATA_W-EV_W){1'b0}}, ev_q}
                              : hit_mask ? {{(DATA_W-MASK_W){1'b0}}, mask_q}
                              : hit_cap ? CAPABILITY_WORD // RL8
                              : hit_pin ? rd_pin
                              : hit_cmd ? {8'h00, protect_q}
                              : hit_cfg ? {{(DATA_W-CFG_W){1'b0}}, cfg_q}
                              : 16'h0000; // RL23

    // =====================================================================
    // register state, power-up reset and one-cycle-late soft reset
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_soft_reset <= 1'b0;
            rdata_q <= '0;
        end
        else
        begin
            o_soft_reset <= soft_reset_d;
            if (go)
            begin
                rdata_q <= rd_word;
            end
        end
    end

    // one block per register; soft reset reloads the power-up value, a pending event is lost
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            ev_q <= EV_RESET; // RL21
        end
        else
        begin
            ev_q <= o_soft_reset ? EV_RESET : ev_d; // RL11
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            mask_q <= MASK_RESET;
        end
        else
        begin
            mask_q <= o_soft_reset ? MASK_RESET : mask_d;
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            protect_q <= LOCK_KEY; // RL20
        end
        else
        begin
            protect_q <= o_soft_reset ? LOCK_KEY : protect_d;
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            unlocked_q <= 1'b0;
        end
        else
        begin
            unlocked_q <= o_soft_reset ? 1'b0 : unlocked_d;
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            cfg_q <= CFG_RESET;
        end
        else
        begin
            cfg_q <= o_soft_reset ? CFG_RESET : cfg_d;
        end
    end

    // =====================================================================
    // registered outputs to the port logic
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_irq <= 1'b0;
            o_sleep_fault_cycles <= '0;
            o_sleep_fault_timer_en <= 1'b0;
        end
        else
        begin
            o_irq <= irq_d;
            o_sleep_fault_cycles <= sleep_cycles_d;
            o_sleep_fault_timer_en <= sleep_sel != SLEEP_SEL_OFF; // RL17
        end
    end

    assign o_write_unlocked = unlocked_q;
    assign o_ignore_return_faults = cfg_q[CFG_IGNORE_RETURN]; // RL15
    assign o_overload_timer_off = cfg_q[CFG_OVERLOAD_OFF]; // RL16
    assign o_nv_refresh_req = cfg_q[CFG_REFRESH]; // RL18
    assign o_supply_ready_flag = cfg_q[CFG_SUPPLY_READY]; // RL19

endmodule : pgc_global_regs

// ### src/pgc_pkg.sv
// constants, field layout and types for the global control register set
//
// Notes on behaviour
// RL1: undervoltage flag, event bit 4, set after core lockout; always interrupts.
// RL2: command fault, event bit 3, set on invalid or disallowed host command.
// RL3: packet check error flag, event bit 2, set when a frame fails its check.
// RL4: memory fault flag, event bit 1, set when internal memory reports a fault.
// RL5: return path breaker flag, event bit 0, breaker trip or deep sleep path fault.
// RL6: events readable; writing 1 clears a flag, 0 leaves it; bits 15:5 reserved.
// RL7: mask bits 3:0 gate the four maskable events onto the interrupt; 15:4 reserved.
// RL8: capability word: protocol bit 6, wake forwarding bit 5, port count 4:0.
// RL9: pin status bits 8:4 show power good of ports 4 down to 0.
// RL10: pin status bit 3 auto pin, bit 2 host wake level, bit 1 own wake drive.
// RL11: code 0x73 written to command upper byte resets the digital logic.
// RL12: key 0x05 in command low byte unlocks all writable registers.
// RL13: key 0xa0 in command low byte locks all writable registers; the code locks only the mask and config registers.
// RL14: command low byte accepts writes whether locked or unlocked.
// RL15: config bit 5 keeps ports out of overload caused by return path faults.
// RL16: config bit 4 disables the overload timers of all ports.
// RL17: config bits 3:2 pick sleep fault timer 15.6, 31.2, 62.5 ms or off.
// RL18: config bit 1 starts a nonvolatile refresh and clears itself when done.
// RL19: config bit 0 is the host supply ready flag, held by the device.
// RL20: command register reads 0x00a0 after reset, so writes start locked.
// RL21: event register reads 0x0010 after reset, undervoltage flag already set.
// RL22: interrupt while undervoltage flag set or any flag set with its mask bit.
// RL23: reserved bits read zero; locked writes leave protected registers unchanged.
package pgc_pkg;

    // =====================================================================
    // register offsets and widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam logic [7:0] OFS_FAULT_EVENTS = 8'h02;
    localparam logic [7:0] OFS_FAULT_MASK = 8'h03;
    localparam logic [7:0] OFS_CAPABILITY = 8'h06;
    localparam logic [7:0] OFS_PIN_STATUS = 8'h07;
    localparam logic [7:0] OFS_COMMAND = 8'h08;
    localparam logic [7:0] OFS_CONFIG = 8'h09;

    // =====================================================================
    // field positions
    localparam int EV_W = 5;
    localparam int EV_UNDERVOLTAGE = 4;
    localparam int EV_COMMAND = 3;
    localparam int EV_PACKET_CHECK = 2;
    localparam int EV_MEMORY = 1;
    localparam int EV_RETURN_PATH = 0;
    localparam int MASK_W = 4;
    localparam int CFG_W = 6;
    localparam int CFG_IGNORE_RETURN = 5;
    localparam int CFG_OVERLOAD_OFF = 4;
    localparam int CFG_SLEEP_SEL_HI = 3;
    localparam int CFG_SLEEP_SEL_LO = 2;
    localparam int CFG_REFRESH = 1;
    localparam int CFG_SUPPLY_READY = 0;
    localparam int PIN_W = 8;
    localparam int PIN_LSB = 1;
    localparam int NUM_PORTS = 5;

    // =====================================================================
    // reset values, keys and fixed words
    localparam logic [EV_W-1:0] EV_RESET = 5'h10;
    localparam logic [MASK_W-1:0] MASK_RESET = 4'hf;
    localparam logic [CFG_W-1:0] CFG_RESET = 6'h09;
    localparam logic [7:0] LOCK_KEY = 8'ha0;
    localparam logic [7:0] UNLOCK_KEY = 8'h05;
    localparam logic [7:0] SOFT_RESET_CODE = 8'h73;
    localparam logic [15:0] CAPABILITY_WORD = 16'h0025;
    localparam logic [1:0] SLEEP_SEL_OFF = 2'h3;

    // =====================================================================
    // sleep fault timer lengths
    localparam int CLOCK_HZ = 50_000_000;
    localparam int SLEEP_T0_US = 15600;
    localparam int SLEEP_T1_US = 31200;
    localparam int SLEEP_T2_US = 62500;
    localparam int SLEEP_T0_CYC = SLEEP_T0_US * (CLOCK_HZ / 1_000_000);
    localparam int SLEEP_T1_CYC = SLEEP_T1_US * (CLOCK_HZ / 1_000_000);
    localparam int SLEEP_T2_CYC = SLEEP_T2_US * (CLOCK_HZ / 1_000_000);
    localparam int SLEEP_CNT_W = 22;

    // =====================================================================
    // types
    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic packet_error;
    } pgc_request_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } pgc_state_t;

endpackage : pgc_pkg

// ### src/pgc_sync.sv
// two flip-flop synchroniser bank
`timescale 1ns/1ns
module pgc_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_reset_n,
    // data
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            meta_q <= '0;
            o_sync <= '0;
        end
        else
        begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end

endmodule : pgc_sync
